/* inc/sbpr_defs.vh */
// Offsets, field positions, reset values and codes of the socket pointer register bank
`ifndef SBPR_DEFS_VH
`define SBPR_DEFS_VH
`define SBPR_OFF_TXBUF_SIZE 8'h1f
`define SBPR_OFF_TX_FREE_HI 8'h20
`define SBPR_OFF_TX_FREE_LO 8'h21
`define SBPR_OFF_TX_RD_HI 8'h22
`define SBPR_OFF_TX_RD_LO 8'h23
`define SBPR_OFF_TX_WR_HI 8'h24
`define SBPR_OFF_TX_WR_LO 8'h25
`define SBPR_OFF_RX_SIZE_HI 8'h26
`define SBPR_OFF_RX_SIZE_LO 8'h27
`define SBPR_OFF_RX_RD_HI 8'h28
`define SBPR_OFF_RX_RD_LO 8'h29
`define SBPR_OFF_RX_WR_HI 8'h2a
`define SBPR_OFF_RX_WR_LO 8'h2b
`define SBPR_OFF_INT_MASK 8'h2c
`define SBPR_OFF_FRAG_HI 8'h2d
`define SBPR_OFF_FRAG_LO 8'h2e
`define SBPR_OFF_OPT_TWO 8'h2f
`define SBPR_RST_TXBUF_SIZE 8'h02
`define SBPR_RST_INT_MASK 8'hff
`define SBPR_RST_FRAG 16'h4000
`define SBPR_RST_OPT_TWO 8'h00
`define SBPR_RST_TX_FREE 16'h0800
`define SBPR_INT_MASK_BITS 8'h1f
`define SBPR_OPT_TWO_BITS 8'h73
`define SBPR_OPT_BCAST_MAC 6
`define SBPR_OPT_MCAST_MAC 5
`define SBPR_OPT_V6_MAC 4
`define SBPR_OPT_UDP_BCAST 1
`define SBPR_OPT_PUSH 1
`define SBPR_OPT_UNICAST 0
`define SBPR_MODE_CLOSED 3'h0
`define SBPR_MODE_TCP 3'h1
`define SBPR_MODE_UDP 3'h2
`define SBPR_MODE_UDP_MCAST 3'h3
`define SBPR_MODE_RAW_IP 3'h4
`define SBPR_MODE_RAW_MAC 3'h5
`define SBPR_TX_MEM_BASE 16'h0000
`define SBPR_MAX_TOTAL_KB 5'h08
`endif

/* hdl/sbpr_socket_regs.v */
// Per-socket buffer pointer, mask, fragment and option register bank
`timescale 1ns/1ps
`default_nettype none
`include "sbpr_defs.vh"

// Overview of operation
// - Size codes 0,1,2,4,8 give that many KB
// - Transmit regions laid out socket 0 upward
// - UDP/raw free space is abs(wr-rd)+1
// - TCP free space uses ack pointer
// - Read pointer set at open, TCP setup
// - Send done: read pointer to write, flag
// - Received size is abs(rx wr - rx rd)
// - Stored data advances receive write pointer
// - Mask gates five interrupt flags
// - Fragment field into IP header, reset 4000
// - Raw MAC bit 6 blocks broadcast
// - Raw MAC bit 5 blocks multicast
// - Raw MAC bit 4 blocks IPv6
// - UDP bit 1 blocks broadcast
// - TCP bit 1 forces PSH flag
// - UDP multicast bit 0 blocks unicast
// - Transmit buffer is a ring: base plus masked pointer
module sbpr_socket_regs (
    input wire sys_clk,
    input wire rst,
    input wire [1:0] socket_index,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] size_sel_s0,
    input wire [7:0] size_sel_s1,
    input wire [7:0] size_sel_s2,
    input wire [2:0] socket_mode,
    input wire open_cmd,
    input wire receive_done_cmd,
    input wire tcp_setup_load,
    input wire [15:0] tcp_setup_value,
    input wire tcp_ack_load,
    input wire [15:0] tcp_ack_value,
    input wire tx_done,
    input wire rx_store,
    input wire [15:0] rx_store_len,
    input wire [4:0] socket_int_flags,
    input wire rx_is_bcast,
    input wire rx_is_mcast,
    input wire rx_is_v6,
    input wire rx_is_udp_bcast,
    input wire rx_is_unicast,
    input wire [15:0] tx_ptr_in,
    input wire [15:0] rx_ptr_in,
    output wire transmit_complete_flag,
    output wire [4:0] int_pending,
    output wire socket_int,
    output reg [15:0] tx_free_space,
    output reg [15:0] rx_received_size,
    output reg [15:0] tx_buffer_base,
    output reg [15:0] tx_buffer_mask,
    output reg [15:0] tx_phys_addr,
    output reg [15:0] rx_phys_addr,
    output reg size_total_error,
    output wire [15:0] ip_frag_field,
    output wire rx_frame_drop,
    output wire force_push
);

    reg [7:0] tx_buffer_size_sel_r;
    reg [15:0] tx_read_pointer_r;
    reg [15:0] tx_write_pointer_r;
    reg [15:0] rx_read_pointer_r;
    reg [15:0] rx_read_shadow_r;
    reg [15:0] rx_write_pointer_r;
    reg [15:0] tcp_ack_pointer_r;
    reg [7:0] socket_int_mask_r;
    reg [15:0] ip_fragment_offset_r;
    reg [7:0] socket_option_two_r;
    reg [7:0] option_live_r;
    reg send_ok_r;
    reg [7:0] rdata_nxt;
    reg [15:0] free_nxt;
    reg [15:0] base_nxt;
    reg opened_r;
    wire [4:0] kb_s0;
    wire [4:0] kb_s1;
    wire [4:0] kb_s2;
    wire [4:0] kb_own;
    wire [15:0] own_mask;
    wire [6:0] total_kb;
    wire mode_tcp;
    wire mode_udp;
    wire mode_udp_mcast;
    wire mode_raw_mac;
    wire wr_size_sel;
    wire wr_tx_wr_hi;
    wire wr_tx_wr_lo;
    wire wr_rx_rd_hi;
    wire wr_rx_rd_lo;
    wire wr_int_mask;
    wire wr_frag_hi;
    wire wr_frag_lo;
    wire wr_opt_two;
    wire drop_bcast;
    wire drop_mcast;
    wire drop_v6;
    wire drop_udp_bcast;
    wire drop_unicast;

    // Size code to kilobytes; illegal codes give no memory
    function [4:0] size_kb;
        input [7:0] code;
        begin
            case (code)
                8'h01: size_kb = 5'h01;
                8'h02: size_kb = 5'h02;
                8'h04: size_kb = 5'h04;
                8'h08: size_kb = 5'h08;
                default: size_kb = 5'h00;
            endcase
        end
    endfunction

    function [15:0] abs_diff;
        input [15:0] a;
        input [15:0] b;
        begin
            abs_diff = (a >= b) ? (a - b) : (b - a);
        end
    endfunction

    function [15:0] kb_bytes;
        input [4:0] kb;
        begin
            kb_bytes = {1'b0, kb, 10'h000};
        end
    endfunction

    // Write strobe aimed at one offset
    function wr_hit;
        input [7:0] addr;
        input [7:0] offset;
        input strobe;
        begin
            wr_hit = strobe && (addr == offset);
        end
    endfunction

    // Decoded write strobes
    assign wr_size_sel = wr_hit(reg_addr, `SBPR_OFF_TXBUF_SIZE, reg_wr);
    assign wr_tx_wr_hi = wr_hit(reg_addr, `SBPR_OFF_TX_WR_HI, reg_wr);
    assign wr_tx_wr_lo = wr_hit(reg_addr, `SBPR_OFF_TX_WR_LO, reg_wr);
    assign wr_rx_rd_hi = wr_hit(reg_addr, `SBPR_OFF_RX_RD_HI, reg_wr);
    assign wr_rx_rd_lo = wr_hit(reg_addr, `SBPR_OFF_RX_RD_LO, reg_wr);
    assign wr_int_mask = wr_hit(reg_addr, `SBPR_OFF_INT_MASK, reg_wr);
    assign wr_frag_hi = wr_hit(reg_addr, `SBPR_OFF_FRAG_HI, reg_wr);
    assign wr_frag_lo = wr_hit(reg_addr, `SBPR_OFF_FRAG_LO, reg_wr);
    assign wr_opt_two = wr_hit(reg_addr, `SBPR_OFF_OPT_TWO, reg_wr);

    // Mode decodes
    assign mode_tcp = (socket_mode == `SBPR_MODE_TCP);
    assign mode_udp = (socket_mode == `SBPR_MODE_UDP);
    assign mode_udp_mcast = (socket_mode == `SBPR_MODE_UDP_MCAST);
    assign mode_raw_mac = (socket_mode == `SBPR_MODE_RAW_MAC);

    // Buffer sizes in kilobytes
    assign kb_s0 = size_kb(size_sel_s0);
    assign kb_s1 = size_kb(size_sel_s1);
    assign kb_s2 = size_kb(size_sel_s2);
    assign kb_own = size_kb(tx_buffer_size_sel_r);
    assign own_mask = kb_bytes(kb_own) - 16'h0001;
    assign total_kb = {2'b00, kb_s0} + {2'b00, kb_s1} + {2'b00, kb_s2} + {2'b00, kb_own};

    // Host-written configuration registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_buffer_size_sel_r <= `SBPR_RST_TXBUF_SIZE;
            socket_int_mask_r <= `SBPR_RST_INT_MASK;
            ip_fragment_offset_r <= `SBPR_RST_FRAG;
            socket_option_two_r <= `SBPR_RST_OPT_TWO;
            option_live_r <= `SBPR_RST_OPT_TWO;
            opened_r <= 1'b0;
        end else begin
            if (wr_size_sel) begin
                tx_buffer_size_sel_r <= reg_wdata;
            end
            if (wr_int_mask) begin
                socket_int_mask_r <= reg_wdata & `SBPR_INT_MASK_BITS;
            end
            if (wr_frag_hi) begin
                ip_fragment_offset_r[15:8] <= reg_wdata;
            end
            if (wr_frag_lo) begin
                ip_fragment_offset_r[7:0] <= reg_wdata;
            end
            if (wr_opt_two) begin
                socket_option_two_r <= reg_wdata & `SBPR_OPT_TWO_BITS;
            end
            // Options only reach the filters when the socket opens
            if (open_cmd) begin
                option_live_r <= socket_option_two_r;
                opened_r <= 1'b1;
            end
        end
    end

    // Transmit pointers; open has priority over every other load
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_read_pointer_r <= 16'h0000;
            tx_write_pointer_r <= 16'h0000;
            tcp_ack_pointer_r <= 16'h0000;
            send_ok_r <= 1'b0;
        end else begin
            send_ok_r <= tx_done && !open_cmd;
            if (open_cmd) begin
                tx_read_pointer_r <= tx_ptr_in;
                tx_write_pointer_r <= tx_ptr_in;
                tcp_ack_pointer_r <= tx_ptr_in;
            end else begin
                if (wr_tx_wr_hi) begin
                    tx_write_pointer_r[15:8] <= reg_wdata;
                end
                if (wr_tx_wr_lo) begin
                    tx_write_pointer_r[7:0] <= reg_wdata;
                end
                if (tcp_setup_load) begin
                    tx_read_pointer_r <= tcp_setup_value;
                    tcp_ack_pointer_r <= tcp_setup_value;
                end else begin
                    if (tx_done) begin
                        tx_read_pointer_r <= tx_write_pointer_r;
                    end
                    if (tcp_ack_load) begin
                        tcp_ack_pointer_r <= tcp_ack_value;
                    end
                end
            end
        end
    end

    // Receive pointers; host writes land in a shadow until receive-done
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_read_pointer_r <= 16'h0000;
            rx_read_shadow_r <= 16'h0000;
            rx_write_pointer_r <= 16'h0000;
        end else begin
            if (open_cmd) begin
                rx_read_pointer_r <= rx_ptr_in;
                rx_read_shadow_r <= rx_ptr_in;
                rx_write_pointer_r <= rx_ptr_in;
            end else begin
                if (wr_rx_rd_hi) begin
                    rx_read_shadow_r[15:8] <= reg_wdata;
                end
                if (wr_rx_rd_lo) begin
                    rx_read_shadow_r[7:0] <= reg_wdata;
                end
                if (receive_done_cmd) begin
                    rx_read_pointer_r <= rx_read_shadow_r;
                end
                if (rx_store) begin
                    rx_write_pointer_r <= rx_write_pointer_r + rx_store_len;
                end
            end
        end
    end

    assign transmit_complete_flag = send_ok_r;
    assign int_pending = socket_int_flags & socket_int_mask_r[4:0];
    assign socket_int = |int_pending;
    assign ip_frag_field = ip_fragment_offset_r;

    // Receive filtering and push forcing from options captured at open
    assign drop_bcast = mode_raw_mac &&
        option_live_r[`SBPR_OPT_BCAST_MAC] && rx_is_bcast;
    assign drop_mcast = mode_raw_mac &&
        option_live_r[`SBPR_OPT_MCAST_MAC] && rx_is_mcast;
    assign drop_v6 = mode_raw_mac &&
        option_live_r[`SBPR_OPT_V6_MAC] && rx_is_v6;
    assign drop_udp_bcast = mode_udp &&
        option_live_r[`SBPR_OPT_UDP_BCAST] && rx_is_udp_bcast;
    assign drop_unicast = mode_udp_mcast &&
        option_live_r[`SBPR_OPT_UNICAST] && rx_is_unicast;
    assign rx_frame_drop = drop_bcast || drop_mcast || drop_v6 ||
        drop_udp_bcast || drop_unicast;
    assign force_push = mode_tcp && option_live_r[`SBPR_OPT_PUSH];

    // Free space keeps its reset value until the socket is first opened
    always @* begin
        if (!opened_r) begin
            free_nxt = `SBPR_RST_TX_FREE;
        end else if (mode_tcp) begin
            free_nxt = abs_diff(tx_write_pointer_r, tcp_ack_pointer_r) + 16'h0001;
        end else begin
            free_nxt = abs_diff(tx_write_pointer_r, tx_read_pointer_r) + 16'h0001;
        end
    end

    // Region base follows the regions of lower sockets
    always @* begin
        case (socket_index)
            2'h0: base_nxt = `SBPR_TX_MEM_BASE;
            2'h1: base_nxt = `SBPR_TX_MEM_BASE + kb_bytes(kb_s0);
            2'h2: base_nxt = `SBPR_TX_MEM_BASE + kb_bytes(kb_s0) + kb_bytes(kb_s1);
            default: base_nxt = `SBPR_TX_MEM_BASE + kb_bytes(kb_s0) + kb_bytes(kb_s1) +
                kb_bytes(kb_s2);
        endcase
    end

    // Derived values registered so data outputs come from flip-flops
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_free_space <= `SBPR_RST_TX_FREE;
            rx_received_size <= 16'h0000;
            tx_buffer_base <= 16'h0000;
            tx_buffer_mask <= 16'h0000;
            tx_phys_addr <= 16'h0000;
            rx_phys_addr <= 16'h0000;
            size_total_error <= 1'b0;
        end else begin
            tx_free_space <= free_nxt;
            rx_received_size <= abs_diff(rx_write_pointer_r, rx_read_pointer_r);
            tx_buffer_base <= base_nxt;
            tx_buffer_mask <= own_mask;
            tx_phys_addr <= base_nxt + (tx_read_pointer_r & own_mask);
            rx_phys_addr <= rx_read_pointer_r;
            // Sum is wide enough that four 8KB codes cannot wrap to zero
            size_total_error <= total_kb > {2'b00, `SBPR_MAX_TOTAL_KB};
        end
    end

    // Read data one cycle after the read strobe; unmapped reads give zero
    always @* begin
        case (reg_addr)
            `SBPR_OFF_TXBUF_SIZE: rdata_nxt = tx_buffer_size_sel_r;
            `SBPR_OFF_TX_FREE_HI: rdata_nxt = free_nxt[15:8];
            `SBPR_OFF_TX_FREE_LO: rdata_nxt = free_nxt[7:0];
            `SBPR_OFF_TX_RD_HI: rdata_nxt = tx_read_pointer_r[15:8];
            `SBPR_OFF_TX_RD_LO: rdata_nxt = tx_read_pointer_r[7:0];
            `SBPR_OFF_TX_WR_HI: rdata_nxt = tx_write_pointer_r[15:8];
            `SBPR_OFF_TX_WR_LO: rdata_nxt = tx_write_pointer_r[7:0];
            `SBPR_OFF_RX_SIZE_HI: rdata_nxt = rx_received_size[15:8];
            `SBPR_OFF_RX_SIZE_LO: rdata_nxt = rx_received_size[7:0];
            `SBPR_OFF_RX_RD_HI: rdata_nxt = rx_read_shadow_r[15:8];
            `SBPR_OFF_RX_RD_LO: rdata_nxt = rx_read_shadow_r[7:0];
            `SBPR_OFF_RX_WR_HI: rdata_nxt = rx_write_pointer_r[15:8];
            `SBPR_OFF_RX_WR_LO: rdata_nxt = rx_write_pointer_r[7:0];
            `SBPR_OFF_INT_MASK: rdata_nxt = socket_int_mask_r;
            `SBPR_OFF_FRAG_HI: rdata_nxt = ip_fragment_offset_r[15:8];
            `SBPR_OFF_FRAG_LO: rdata_nxt = ip_fragment_offset_r[7:0];
            `SBPR_OFF_OPT_TWO: rdata_nxt = socket_option_two_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // sbpr_socket_regs
`default_nettype wire

/* verification/sbpr_socket_regs_chk.sv */
// Concurrent checks on the ports of the socket pointer register bank
`timescale 1ns/1ps
`default_nettype none
module sbpr_socket_regs_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] socket_mode,
    input wire logic tx_done,
    input wire logic reg_wr,
    input wire logic open_cmd,
    input wire logic [4:0] socket_int_flags,
    input wire logic rx_is_bcast,
    input wire logic rx_is_mcast,
    input wire logic rx_is_v6,
    input wire logic rx_is_udp_bcast,
    input wire logic rx_is_unicast,
    input wire logic transmit_complete_flag,
    input wire logic [4:0] int_pending,
    input wire logic socket_int,
    input wire logic [15:0] tx_free_space,
    input wire logic [15:0] tx_buffer_mask,
    input wire logic [15:0] ip_frag_field,
    input wire logic rx_frame_drop,
    input wire logic force_push
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_flag_after_done: assert property (
        tx_done && !open_cmd |=> transmit_complete_flag) else $error("send flag missing");
    a_flag_cause: assert property (
        transmit_complete_flag |-> $past(tx_done)) else $error("stray send flag");
    a_mask_gate: assert property (
        (int_pending & ~socket_int_flags) == 5'h00 && socket_int == (|int_pending))
        else $error("interrupt gating wrong");
    a_frag_read: assert property (
        reg_rd && reg_addr == 8'h2d |=> reg_rdata == ip_frag_field[15:8])
        else $error("fragment read wrong");
    a_push_tcp: assert property (
        force_push |-> socket_mode == 3'h1) else $error("push outside tcp");
    a_drop_cause: assert property (
        rx_frame_drop |-> (socket_mode == 3'h5 && (rx_is_bcast || rx_is_mcast || rx_is_v6))
        || (socket_mode[2:1] == 2'b01 && (rx_is_udp_bcast || rx_is_unicast)))
        else $error("drop without cause");
    a_udp_free_one: assert property (
        tx_done && socket_mode == 3'h2 && !open_cmd && !reg_wr ##1
        socket_mode == 3'h2 |=> tx_free_space == 16'h0001) else $error("free space wrong");
    a_ring_mask: assert property (
        $onehot0(16'(tx_buffer_mask + 16'h0001))) else $error("ring mask wrong");
    c_send: cover property (tx_done ##1 transmit_complete_flag);
    c_drop: cover property (rx_frame_drop);
    c_push: cover property (force_push);
endmodule // sbpr_socket_regs_chk
bind sbpr_socket_regs sbpr_socket_regs_chk chk_i (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .socket_mode(socket_mode),
    .tx_done(tx_done), .reg_wr(reg_wr), .open_cmd(open_cmd), .socket_int_flags(socket_int_flags),
    .rx_is_bcast(rx_is_bcast), .rx_is_mcast(rx_is_mcast), .rx_is_v6(rx_is_v6),
    .rx_is_udp_bcast(rx_is_udp_bcast), .rx_is_unicast(rx_is_unicast),
    .transmit_complete_flag(transmit_complete_flag), .int_pending(int_pending),
    .socket_int(socket_int), .tx_free_space(tx_free_space), .tx_buffer_mask(tx_buffer_mask),
    .ip_frag_field(ip_frag_field), .rx_frame_drop(rx_frame_drop), .force_push(force_push));
`default_nettype wire

/* verification/sbpr_host_model.sv */
// Host model driving the register port and socket commands
`timescale 1ns/1ps
`default_nettype none
module sbpr_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic open_cmd = 1'b0,
    output logic receive_done_cmd = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // 16-bit write: high byte at the offset, then low byte at the next one
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h01, d[7:0]);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        logic [7:0] h;
        logic [7:0] l;
        rd(a, h);
        rd(a + 8'h01, l);
        d = {h, l};
    endtask
    // Issues open when op is set, otherwise receive-done, each for one cycle
    task automatic cmd(input logic op);
        @(posedge sys_clk);
        open_cmd <= op;
        receive_done_cmd <= !op;
        @(posedge sys_clk);
        open_cmd <= 1'b0;
        receive_done_cmd <= 1'b0;
    endtask
endmodule // sbpr_host_model
`default_nettype wire

/* verification/sbpr_socket_regs_tb.sv */
// Self-checking bench for the socket pointer register bank
`timescale 1ns/1ps
`default_nettype none
module sbpr_socket_regs_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata, b;
    logic wr, rd, opn, rdn, tcf, sint, ste, drop, push;
    logic tsl = 0, tal = 0, txd = 0, rxs = 0;
    logic [7:0] s0 = 8'h00, s1 = 8'h00, s2 = 8'h00;
    logic [1:0] sidx = 2'h0;
    logic [15:0] base, tpa, rpa;
    logic [2:0] mode = 3'h0;
    logic [4:0] flg = 5'h00, cls = 5'h00, pend;
    logic [15:0] tsv = 0, tav = 0, rxl = 0, tpi = 0, rpi = 0, w, fsp, rsz, mask, frag;
    int fail_count = 0, check_count = 0, cycles = 0;
    logic [31:0] rows [14] = '{32'h001f_0002, 32'h0020_0008, 32'h0021_0000, 32'h002c_00ff,
        32'h002d_0040, 32'h002e_0000, 32'h002f_0000, 32'h0030_0000, 32'h012c_ff1f,
        32'h012f_ff73, 32'h012d_1212, 32'h011f_0808, 32'h0122_5500, 32'h0130_aa00};
    // Rows: mode, frame class, expected drop
    logic [8:0] drops [8] = '{9'h161, 9'h151, 9'h149, 9'h085, 9'h0c3, 9'h044, 9'h142, 9'h082};
    always #2 sys_clk = ~sys_clk;
    sbpr_host_model sbpr_host_model_i (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .open_cmd(opn), .receive_done_cmd(rdn));
    sbpr_socket_regs sbpr_socket_regs_i (.sys_clk(sys_clk), .rst(rst), .socket_index(sidx),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .size_sel_s0(s0), .size_sel_s1(s1), .size_sel_s2(s2), .socket_mode(mode),
        .open_cmd(opn), .receive_done_cmd(rdn), .tcp_setup_load(tsl), .tcp_setup_value(tsv),
        .tcp_ack_load(tal), .tcp_ack_value(tav), .tx_done(txd), .rx_store(rxs),
        .rx_store_len(rxl), .socket_int_flags(flg), .rx_is_bcast(cls[4]), .rx_is_mcast(cls[3]),
        .rx_is_v6(cls[2]), .rx_is_udp_bcast(cls[1]), .rx_is_unicast(cls[0]), .tx_ptr_in(tpi),
        .rx_ptr_in(rpi), .transmit_complete_flag(tcf), .int_pending(pend), .socket_int(sint),
        .tx_free_space(fsp), .rx_received_size(rsz), .tx_buffer_base(base),
        .tx_buffer_mask(mask), .tx_phys_addr(tpa), .rx_phys_addr(rpa),
        .size_total_error(ste), .ip_frag_field(frag),
        .rx_frame_drop(drop), .force_push(push));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic strobe(input logic [3:0] s);
        @(posedge sys_clk);
        {tsl, tal, txd, rxs} <= s;
        @(posedge sys_clk);
        {tsl, tal, txd, rxs} <= 4'h0;
    endtask
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            if (rows[i][24]) sbpr_host_model_i.wr(rows[i][23:16], rows[i][15:8]);
            sbpr_host_model_i.rd(rows[i][23:16], b);
            check(b, rows[i][7:0]);
        end
        check(frag, 16'h1200);
        check(mask, 16'h1fff);
        check(ste, 0);
        s0 <= 8'h01;
        settle();
        check(ste, 1);
        s0 <= 8'h00;
        $display("register table and sizes done");
        mode <= 3'h2;
        tpi <= 16'hfff0;
        rpi <= 16'h0100;
        sbpr_host_model_i.cmd(1);
        sbpr_host_model_i.wr16(8'h24, 16'h0010);
        sbpr_host_model_i.rd16(8'h20, w);
        check(w, 16'hffe1);
        sbpr_host_model_i.rd16(8'h22, w);
        check(w, 16'hfff0);
        strobe(4'h2);
        @(negedge sys_clk);
        check(tcf, 1);
        sbpr_host_model_i.rd16(8'h22, w);
        check(w, 16'h0010);
        check(fsp, 16'h0001);
        rxl <= 16'h0040;
        strobe(4'h1);
        sbpr_host_model_i.rd16(8'h26, w);
        check(w, 16'h0040);
        sbpr_host_model_i.wr16(8'h28, 16'h0120);
        sbpr_host_model_i.rd16(8'h26, w);
        check(w, 16'h0040);
        sbpr_host_model_i.cmd(0);
        settle();
        check(rsz, 16'h0020);
        $display("udp pointers done");
        mode <= 3'h1;
        tpi <= 16'h0000;
        sbpr_host_model_i.cmd(1);
        settle();
        check(push, 1);
        sbpr_host_model_i.wr16(8'h24, 16'h0010);
        tav <= 16'h0008;
        strobe(4'h4);
        sbpr_host_model_i.rd16(8'h20, w);
        check(w, 16'h0009);
        tsv <= 16'h0004;
        strobe(4'h8);
        sbpr_host_model_i.rd16(8'h22, w);
        check(w, 16'h0004);
        sbpr_host_model_i.rd16(8'h20, w);
        check(w, 16'h000d);
        $display("tcp pointers done");
        sidx <= 2'h3;
        s0 <= 8'h01;
        s1 <= 8'h02;
        s2 <= 8'h04;
        settle();
        check(base, 16'h1c00);
        check(tpa, 16'h1c04);
        check(rpa, 16'h0100);
        sidx <= 2'h2;
        {s0, s1, s2} <= {3{8'h08}};
        settle();
        check(base, 16'h4000);
        check(ste, 1);
        $display("regions done");
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            mode <= drops[i][8:6];
            cls <= drops[i][5:1];
            @(negedge sys_clk);
            check(drop, drops[i][0]);
        end
        check(push, 0);
        sbpr_host_model_i.wr(8'h2f, 8'h00);
        mode <= 3'h5;
        cls <= 5'h10;
        sbpr_host_model_i.cmd(1);
        settle();
        check(drop, 0);
        sbpr_host_model_i.wr(8'h2c, 8'h05);
        flg <= 5'h1f;
        settle();
        check(pend, 16'h0005);
        check(sint, 1);
        flg <= 5'h0a;
        settle();
        check(pend, 0);
        check(sint, 0);
        $display("filters and mask done");
        rst <= 1'b1;
        settle();
        rst <= 1'b0;
        sbpr_host_model_i.rd16(8'h20, w);
        check(w, 16'h0800);
        check(fsp, 16'h0800);
        sbpr_host_model_i.rd16(8'h2d, w);
        check(w, 16'h4000);
        check(pend, 16'h000a);
        check(mask, 16'h07ff);
        $display("mid-run reset done");
        end_of_test();
    end
endmodule // sbpr_socket_regs_tb
`default_nettype wire
